// *** laser_status_pkg.sv ***
/*
  Shared constants and types for the laser fault and signal-loss status block:
  management addresses, status byte layout, management states and loss timing.
  Assumes a 20 MHz system clock.
*/
package laser_status_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 50;
  // Longest quiet time on the received data before loss is flagged
  localparam int LOS_TIME_NS = 100000;
  // A longest time rounds down
  localparam int LOS_CYCLES = (LOS_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                              LOS_TIME_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // Management map
  // ****************************************************************
  localparam logic [6:0] DIAG_DEV_ADDR = 7'h51;
  localparam logic [7:0] CTRL_FLAG_OFS = 8'h6E;
  localparam int HW_DISABLE_BIT = 7;
  localparam int SOFT_DISABLE_BIT = 6;
  localparam int FAULT_BIT = 2;
  localparam int LOSS_BIT = 1;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] UNMAPPED_BYTE = 8'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic hw_disable;
    logic soft_disable;
    logic fault;
    logic loss;
  } status_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_DEV = 4'h1,
    ST_DACK = 4'h3,
    ST_ADDR = 4'h2,
    ST_AACK = 4'h6,
    ST_WR = 4'h7,
    ST_WACK = 4'h5,
    ST_RD = 4'h4,
    ST_RACK = 4'hC
  } mgmt_state_t;

endpackage : laser_status_pkg

// *** signal_loss_detector.sv ***
/*
  Transition detector on the received data: flags loss of modulated signal
  after a quiet stretch and clears on the next transition.
  Assumes the received data bit is synchronous to the clock.
*/
`timescale 1ns/1ns
module signal_loss_detector #(
  parameter int LOS_CYCLES = laser_status_pkg::LOS_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_data,
  output logic loss
);

  localparam int CW = $clog2(LOS_CYCLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(LOS_CYCLES);

  generate
    if (LOS_CYCLES < 1) begin : g_bad
      $error("LOS_CYCLES must be at least one");
    end
  endgenerate

  logic rx_q;
  logic [CW-1:0] quiet;
  logic edge_seen;

  assign edge_seen = rx_q ^ rx_data;

  // Follows the pin through reset so that release never fakes a transition
  always_ff @(posedge clk) begin
    rx_q <= rx_data;
  end

  // ****************************************************************
  // Quiet-time counter and flag
  // ****************************************************************
  // Held at the limit so the counter never wraps during a long outage
  always_ff @(posedge clk) begin
    if (rst) begin
      quiet <= '0;
    end else if (edge_seen) begin
      quiet <= '0;
    end else if (quiet != LIMIT) begin
      quiet <= quiet + CW'(1);
    end
  end

  // Starts flagged: no modulation has been seen yet
  always_ff @(posedge clk) begin
    if (rst) begin
      loss <= 1'b1;
    end else if (edge_seen) begin
      loss <= 1'b0;
    end else if (quiet == LIMIT) begin
      loss <= 1'b1;
    end
  end

endmodule : signal_loss_detector

// *** laser_fault_and_los_status.sv ***
/*
  Fault latch, transmitter gating, signal-loss flag and the two-wire
  management slave that exposes the control and flag byte.
  Assumes SCL and SDA arrive synchronous to CLK_IN and that the system
  reset stands for a power cycle of the module.
*/
// Behaviour
// - A catastrophic laser fault raises the fault output and turns the laser off.
// - Fault output is low in normal operation and high while a fault stands.
// - The fault stays latched until transmit-off is toggled or power is cycled.
// - Bit 2 of the control and flag byte shows the fault state.
// - Signal-loss output is high while no modulated input is seen, else low.
// - Bit 1 of the control and flag byte shows the signal-loss state.
// - An over-limit optical level turns the transmitter off at once.
// - Laser is off when hardware transmit-off or soft bit 6 is set.
// - Bit 7 of the control and flag byte shows the hardware transmit-off input.
`timescale 1ns/1ns
module laser_fault_and_los_status #(
  parameter int LOS_CYCLES = laser_status_pkg::LOS_CYCLES
) (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic TX_DISABLE_IN,
  input wire logic LASER_FAULT_DET_IN,
  input wire logic OPTICAL_OVER_LIMIT_IN,
  input wire logic RX_DATA_IN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic TX_FAULT_OUT,
  output logic LASER_ENABLE_OUT,
  output logic SIGNAL_LOSS_FLAG_OUT,
  output logic SDA_OUT,
  output logic SDA_OE_OUT
);

  // ****************************************************************
  // Status byte decode
  // ****************************************************************
  function automatic logic [7:0] read_byte(input logic [7:0] addr,
                                           input laser_status_pkg::status_t st);
    logic [7:0] b;
    b = laser_status_pkg::UNMAPPED_BYTE;
    if (addr == laser_status_pkg::CTRL_FLAG_OFS) begin
      b[laser_status_pkg::HW_DISABLE_BIT] = st.hw_disable;
      b[laser_status_pkg::SOFT_DISABLE_BIT] = st.soft_disable;
      b[laser_status_pkg::FAULT_BIT] = st.fault;
      b[laser_status_pkg::LOSS_BIT] = st.loss;
    end
    return b;
  endfunction : read_byte

  laser_status_pkg::status_t status;
  laser_status_pkg::mgmt_state_t state;
  logic soft_disable;
  logic disable_q;
  logic toggle_done;
  logic fault_event;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] shift;
  logic [7:0] tx_byte;
  logic [7:0] ptr;
  logic [3:0] cnt;
  logic read_mode;
  logic master_nack;
  logic wr_hit;
  logic [7:0] load_byte;

  assign status = '{hw_disable: TX_DISABLE_IN, soft_disable: soft_disable,
                    fault: TX_FAULT_OUT, loss: SIGNAL_LOSS_FLAG_OUT};
  assign load_byte = read_byte(ptr, status);

  // ****************************************************************
  // Fault latch
  // ****************************************************************
  // Eye-safety trips count as faults so they need the same host toggle
  assign fault_event = LASER_FAULT_DET_IN | OPTICAL_OVER_LIMIT_IN;
  // A host that grounds transmit-off never clears a fault except by power
  assign toggle_done = disable_q & ~TX_DISABLE_IN;

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      disable_q <= 1'b0;
    end else begin
      disable_q <= TX_DISABLE_IN;
    end
  end

  // A fault arriving with the toggle's fall wins over the clear
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      TX_FAULT_OUT <= 1'b0;
    end else if (fault_event) begin
      TX_FAULT_OUT <= 1'b1;
    end else if (toggle_done) begin
      TX_FAULT_OUT <= 1'b0;
    end
  end

  // ****************************************************************
  // Transmitter gating
  // ****************************************************************
  // The live fault inputs gate directly so the laser drops without waiting on the latch
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      LASER_ENABLE_OUT <= 1'b0;
    end else begin
      LASER_ENABLE_OUT <= ~(TX_DISABLE_IN | soft_disable | TX_FAULT_OUT | fault_event);
    end
  end

  // ****************************************************************
  // Signal loss
  // ****************************************************************
  signal_loss_detector #(
    .LOS_CYCLES(LOS_CYCLES)
  ) u_loss (
    .clk(CLK_IN),
    .rst(SYS_RST_IN),
    .rx_data(RX_DATA_IN),
    .loss(SIGNAL_LOSS_FLAG_OUT)
  );

  // ****************************************************************
  // Two-wire management slave
  // ****************************************************************
  assign scl_rise = ~scl_q & SCL_IN;
  assign scl_fall = scl_q & ~SCL_IN;
  assign start_seen = scl_q & SCL_IN & sda_q & ~SDA_IN;
  assign stop_seen = scl_q & SCL_IN & ~sda_q & SDA_IN;
  assign wr_hit = (state == laser_status_pkg::ST_WR) && scl_fall &&
                  (cnt == laser_status_pkg::BITS_PER_BYTE) &&
                  (ptr == laser_status_pkg::CTRL_FLAG_OFS);

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= SCL_IN;
      sda_q <= SDA_IN;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      soft_disable <= 1'b0;
    end else if (wr_hit) begin
      soft_disable <= shift[laser_status_pkg::SOFT_DISABLE_BIT];
    end
  end

  // Open drain: only ever pulls low
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      SDA_OUT <= 1'b0;
    end else begin
      SDA_OUT <= 1'b0;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      state <= laser_status_pkg::ST_IDLE;
      SDA_OE_OUT <= 1'b0;
      shift <= 8'h00;
      tx_byte <= 8'h00;
      ptr <= 8'h00;
      cnt <= 4'h0;
      read_mode <= 1'b0;
      master_nack <= 1'b0;
    end else if (start_seen) begin
      state <= laser_status_pkg::ST_DEV;
      SDA_OE_OUT <= 1'b0;
      cnt <= 4'h0;
    end else if (stop_seen) begin
      state <= laser_status_pkg::ST_IDLE;
      SDA_OE_OUT <= 1'b0;
    end else begin
      case (state)
        laser_status_pkg::ST_DEV, laser_status_pkg::ST_ADDR, laser_status_pkg::ST_WR: begin
          if (scl_rise) begin
            shift <= {shift[6:0], SDA_IN};
            cnt <= cnt + 4'h1;
          end else if (scl_fall && cnt == laser_status_pkg::BITS_PER_BYTE) begin
            cnt <= 4'h0;
            SDA_OE_OUT <= 1'b1;
            if (state == laser_status_pkg::ST_DEV) begin
              read_mode <= shift[0];
              if (shift[7:1] == laser_status_pkg::DIAG_DEV_ADDR) begin
                state <= laser_status_pkg::ST_DACK;
              end else begin
                state <= laser_status_pkg::ST_IDLE;
                SDA_OE_OUT <= 1'b0;
              end
            end else if (state == laser_status_pkg::ST_ADDR) begin
              ptr <= shift;
              state <= laser_status_pkg::ST_AACK;
            end else begin
              ptr <= ptr + 8'h01;
              state <= laser_status_pkg::ST_WACK;
            end
          end
        end
        laser_status_pkg::ST_DACK: begin
          if (scl_fall) begin
            if (read_mode) begin
              tx_byte <= load_byte;
              SDA_OE_OUT <= ~load_byte[7];
              ptr <= ptr + 8'h01;
              state <= laser_status_pkg::ST_RD;
            end else begin
              SDA_OE_OUT <= 1'b0;
              state <= laser_status_pkg::ST_ADDR;
            end
          end
        end
        laser_status_pkg::ST_AACK, laser_status_pkg::ST_WACK: begin
          if (scl_fall) begin
            SDA_OE_OUT <= 1'b0;
            state <= laser_status_pkg::ST_WR;
          end
        end
        laser_status_pkg::ST_RD: begin
          if (scl_rise) begin
            cnt <= cnt + 4'h1;
          end else if (scl_fall) begin
            if (cnt == laser_status_pkg::BITS_PER_BYTE) begin
              cnt <= 4'h0;
              SDA_OE_OUT <= 1'b0;
              state <= laser_status_pkg::ST_RACK;
            end else begin
              SDA_OE_OUT <= ~tx_byte[6];
              tx_byte <= {tx_byte[6:0], 1'b0};
            end
          end
        end
        laser_status_pkg::ST_RACK: begin
          if (scl_rise) begin
            master_nack <= SDA_IN;
          end else if (scl_fall) begin
            if (master_nack) begin
              state <= laser_status_pkg::ST_IDLE;
            end else begin
              tx_byte <= load_byte;
              SDA_OE_OUT <= ~load_byte[7];
              ptr <= ptr + 8'h01;
              state <= laser_status_pkg::ST_RD;
            end
          end
        end
        default: begin
          state <= laser_status_pkg::ST_IDLE;
          SDA_OE_OUT <= 1'b0;
        end
      endcase
    end
  end

endmodule : laser_fault_and_los_status

// *** laser_status_properties.sv ***
/*
  Checker for the laser fault and signal-loss status block.
  Assumes a bind to the top module; sees only its ports.
*/
`timescale 1ns/1ns
module laser_status_properties #(
  parameter int LOS_CYCLES = laser_status_pkg::LOS_CYCLES
) (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic TX_DISABLE_IN,
  input wire logic LASER_FAULT_DET_IN,
  input wire logic OPTICAL_OVER_LIMIT_IN,
  input wire logic RX_DATA_IN,
  input wire logic TX_FAULT_OUT,
  input wire logic LASER_ENABLE_OUT,
  input wire logic SIGNAL_LOSS_FLAG_OUT
);
  // ****************
  // Properties
  // ****************
  logic cause;
  logic rx_prev;
  int quiet;
  assign cause = LASER_FAULT_DET_IN | OPTICAL_OVER_LIMIT_IN;
  // Saturates so a long idle run cannot wrap
  always_ff @(posedge CLK_IN) begin
    rx_prev <= RX_DATA_IN;
    if (SYS_RST_IN) begin
      quiet <= LOS_CYCLES + 4;
    end else if (RX_DATA_IN != rx_prev) begin
      quiet <= 0;
    end else if (quiet < LOS_CYCLES + 4) begin
      quiet <= quiet + 1;
    end
  end
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);
  fault_sets_a: assert property (cause |=> TX_FAULT_OUT)
    else $error("fault input did not raise fault output");
  laser_cut_a: assert property (cause |=> !LASER_ENABLE_OUT)
    else $error("laser enabled after fault input");
  fault_quiet_a: assert property (!TX_FAULT_OUT && !cause |=> !TX_FAULT_OUT)
    else $error("fault output rose without cause");
  fault_held_a: assert property (
    TX_FAULT_OUT && !$fell(TX_DISABLE_IN) |=> TX_FAULT_OUT)
    else $error("fault output dropped without toggle");
  toggle_clear_a: assert property (
    TX_FAULT_OUT && $fell(TX_DISABLE_IN) && !cause |=> !TX_FAULT_OUT)
    else $error("toggle did not clear fault output");
  hw_off_a: assert property (TX_DISABLE_IN |=> !LASER_ENABLE_OUT)
    else $error("laser enabled while transmit-off high");
  enable_rise_a: assert property (
    $rose(LASER_ENABLE_OUT) |-> !$past(TX_DISABLE_IN) && !$past(TX_FAULT_OUT))
    else $error("laser enabled while disabled or faulted");
  loss_low_a: assert property (quiet <= LOS_CYCLES - 2 |-> !SIGNAL_LOSS_FLAG_OUT)
    else $error("loss flag high with recent transitions");
  loss_high_a: assert property (quiet >= LOS_CYCLES + 3 |-> SIGNAL_LOSS_FLAG_OUT)
    else $error("loss flag low after quiet input");
endmodule : laser_status_properties

bind laser_fault_and_los_status laser_status_properties #(
  .LOS_CYCLES(LOS_CYCLES)
) laser_status_properties_inst (
  .CLK_IN(CLK_IN),
  .SYS_RST_IN(SYS_RST_IN),
  .TX_DISABLE_IN(TX_DISABLE_IN),
  .LASER_FAULT_DET_IN(LASER_FAULT_DET_IN),
  .OPTICAL_OVER_LIMIT_IN(OPTICAL_OVER_LIMIT_IN),
  .RX_DATA_IN(RX_DATA_IN),
  .TX_FAULT_OUT(TX_FAULT_OUT),
  .LASER_ENABLE_OUT(LASER_ENABLE_OUT),
  .SIGNAL_LOSS_FLAG_OUT(SIGNAL_LOSS_FLAG_OUT)
);

// *** host_two_wire_master.sv ***
/*
  Host model: two-wire management master.
  Assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/1ns
module host_two_wire_master (
  input wire logic clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_low
);
  // ****************
  // Bus cycles
  // ****************
  // Three clocks a phase give margin over the two-clock minimum
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc
  task automatic put_bit(input logic b, output logic r);
    sda_low = ~b;
    wait_cyc(3);
    scl = 1'b1;
    wait_cyc(3);
    r = sda_in;
    scl = 1'b0;
    wait_cyc(1);
  endtask : put_bit
  task automatic edge_c(input logic stop);
    sda_low = stop;
    wait_cyc(3);
    scl = 1'b1;
    wait_cyc(3);
    sda_low = ~stop;
    wait_cyc(3);
    scl = stop;
    wait_cyc(2);
  endtask : edge_c
  task automatic send_byte(input logic [7:0] b, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], r);
    end
    put_bit(1'b1, nak);
  endtask : send_byte
  // No early abort: an unanswered address just reads back idle ones
  task automatic xfer(input logic [6:0] dev, input logic [7:0] ofs, input logic rd,
                      input logic two, input logic [7:0] wd, output logic [7:0] d,
                      output logic [7:0] d2, output logic [2:0] nak);
    logic r;
    edge_c(1'b0);
    send_byte({dev, 1'b0}, nak[2]);
    send_byte(ofs, nak[1]);
    d = wd;
    d2 = wd;
    if (rd) begin
      edge_c(1'b0);
      send_byte({dev, 1'b1}, nak[0]);
      for (int i = 7; i >= 0; i--) begin
        put_bit(1'b1, d[i]);
      end
      // Acknowledge the first byte only when a second one follows
      put_bit(~two, r);
      if (two) begin
        for (int i = 7; i >= 0; i--) begin
          put_bit(1'b1, d2[i]);
        end
        put_bit(1'b1, r);
      end
    end else begin
      send_byte(wd, nak[0]);
      if (two) begin
        send_byte(wd, r);
        nak[0] = nak[0] | r;
      end
    end
    edge_c(1'b1);
  endtask : xfer
endmodule : host_two_wire_master

// *** tb.sv ***
/*
  Bench for the laser fault and signal-loss block against a host model.
  Assumes a 20 MHz clock and a pulled-up data wire.
*/
`timescale 1ns/1ns
module tb;
  // ****************
  // Bench
  // ****************
  logic clk = 1'b0, rst = 1'b1, txd = 1'b0, flt = 1'b0, ovl = 1'b0, rxd = 1'b0;
  logic scl, sda_low, sda, fault, en, loss, sda_oe, sdo, rx_run = 1'b0;
  logic [7:0] d, d2;
  logic [2:0] nak;
  int errors = 0, check_count = 0, cycles = 0, seed = 32'h7046;
  int m_fault = 0, m_soft = 0, m_loss = 1;
  assign sda = ~(sda_low | sda_oe);
  always #25 clk = ~clk;
  laser_fault_and_los_status #(.LOS_CYCLES(8)) laser_fault_and_los_status_inst (
    .CLK_IN(clk), .SYS_RST_IN(rst), .TX_DISABLE_IN(txd), .LASER_FAULT_DET_IN(flt),
    .OPTICAL_OVER_LIMIT_IN(ovl), .RX_DATA_IN(rxd), .SCL_IN(scl), .SDA_IN(sda),
    .TX_FAULT_OUT(fault), .LASER_ENABLE_OUT(en), .SIGNAL_LOSS_FLAG_OUT(loss),
    .SDA_OUT(sdo), .SDA_OE_OUT(sda_oe));
  host_two_wire_master host_two_wire_master_inst (
    .clk(clk), .sda_in(sda), .scl(scl), .sda_low(sda_low));
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end
  always @(posedge clk) begin
    #1;
    if (rx_run) rxd = ~rxd;
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic pins(input string t);
    check("fault", 8'(fault), 8'(m_fault[0]));
    check("enable", 8'(en), 8'(!(txd | m_soft[0] | m_fault[0])));
    check("loss", 8'(loss), 8'(m_loss[0]));
    check("data drive", 8'(sdo), 8'h00);
    $display("test %s done", t);
  endtask : pins
  function automatic logic [7:0] exp_byte();
    return {txd, m_soft[0], 3'h0, m_fault[0], m_loss[0], 1'b0};
  endfunction : exp_byte
  task automatic xfer(input logic [7:0] ofs, input logic rd, input logic two,
                      input logic [7:0] wd);
    host_two_wire_master_inst.xfer(laser_status_pkg::DIAG_DEV_ADDR, ofs, rd, two, wd,
                                   d, d2, nak);
    check("acks", 8'(nak), 8'h00);
  endtask : xfer
  task automatic reg_rd();
    xfer(laser_status_pkg::CTRL_FLAG_OFS, 1'b1, 1'b0, 8'h00);
    check("byte", d, exp_byte());
  endtask : reg_rd
  task automatic toggle_off();
    txd = 1'b1;
    tick(3);
    pins("hold");
    reg_rd();
    txd = 1'b0;
    m_fault = 0;
    tick(3);
    pins("clear");
  endtask : toggle_off
  initial begin
    tick(5);
    rst = 1'b0;
    tick(3);
    pins("reset");
    reg_rd();
    flt = 1'b1;
    tick(1 + $unsigned($random(seed)) % 4);
    flt = 1'b0;
    m_fault = 1;
    tick(2);
    pins("fault");
    reg_rd();
    toggle_off();
    ovl = 1'b1;
    txd = 1'b1;
    tick(2);
    txd = 1'b0;
    m_fault = 1;
    tick(2);
    ovl = 1'b0;
    tick(2);
    pins("limit");
    toggle_off();
    // Two-byte write from the byte below: only the second one lands on the flag byte
    xfer(laser_status_pkg::CTRL_FLAG_OFS - 8'h01, 1'b0, 1'b1, 8'hFF);
    m_soft = 1;
    tick(2);
    pins("soft");
    reg_rd();
    xfer(laser_status_pkg::CTRL_FLAG_OFS - 8'h01, 1'b1, 1'b1, 8'h00);
    check("burst first", d, 8'h00);
    check("burst second", d2, exp_byte());
    xfer(laser_status_pkg::CTRL_FLAG_OFS, 1'b0, 1'b0, 8'h00);
    m_soft = 0;
    xfer(8'h70, 1'b0, 1'b0, 8'($random(seed)));
    xfer(8'h70, 1'b1, 1'b0, 8'h00);
    check("unmapped", d, 8'h00);
    host_two_wire_master_inst.xfer(7'h50, 8'h6E, 1'b1, 1'b0, 8'h00, d, d2, nak);
    check("other acks", 8'(nak), 8'h07);
    check("other data", d, 8'hFF);
    rx_run = 1'b1;
    tick(4);
    m_loss = 0;
    pins("signal");
    reg_rd();
    rx_run = 1'b0;
    tick(12);
    m_loss = 1;
    pins("quiet");
    reg_rd();
    flt = 1'b1;
    tick(1);
    flt = 1'b0;
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    m_fault = 0;
    tick(3);
    pins("power cycle");
    conclude();
  end
endmodule : tb
